// >>> verilog/dnc_pkg.sv
// Purpose: Shared constants for the downconverter channel configuration.
// Assumes: Registers are 8 bits wide and sit in the low lane of a word.
// Notes:   Register indices are word indices; byte address is four times.
package dnc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register indices and reset values.
  localparam logic [9:0] DNC_IDX_CTRL  = 10'h370;
  localparam logic [9:0] DNC_IDX_INSEL = 10'h371;
  localparam logic [9:0] DNC_IDX_NCO   = 10'h374;
  localparam logic [7:0] DNC_CTRL_RST  = 8'h00;
  localparam logic [7:0] DNC_INSEL_RST = 8'h01;
  localparam logic [7:0] DNC_NCO_RST   = 8'h00;
  // Cascade outputs before the first clock out of reset decode code 000.
  localparam logic [5:0] DNC_STAGE_RST = 6'h03;
  localparam logic [5:0] DNC_DEC_RST   = 6'h04;
  // Writable bits of the input select register; bits 3 and 1 stay zero.
  localparam logic [7:0] DNC_INSEL_WMASK = 8'hf5;
  localparam logic [7:0] DNC_CTRL_WMASK  = 8'h0f;

  ////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int DNC_DEC_LSB  = 0;
  localparam int DNC_C2R_BIT  = 3;
  localparam int DNC_SEC_LSB  = 4;
  localparam int DNC_I_BIT    = 0;
  localparam int DNC_Q_BIT    = 2;
  localparam int DNC_CHAN_LSB = 0;
  localparam int DNC_MODE_LSB = 4;

  ////////////////////////////////////////////////////////////////////////
  // Decimation codes, oscillator select modes and stage positions.
  localparam logic [2:0] DNC_DEC_HB12   = 3'h0;
  localparam logic [2:0] DNC_DEC_HB123  = 3'h1;
  localparam logic [2:0] DNC_DEC_HB1234 = 3'h2;
  localparam logic [2:0] DNC_DEC_HB1    = 3'h3;
  localparam logic [2:0] DNC_DEC_HB1_TB = 3'h4;
  localparam logic [2:0] DNC_DEC_HB2_TB = 3'h5;
  localparam logic [2:0] DNC_DEC_HB3_TB = 3'h6;
  localparam logic [2:0] DNC_DEC_SEC    = 3'h7;
  localparam logic [3:0] DNC_SEC_HB4_TB = 4'h0;
  localparam logic [3:0] DNC_SEC_HB1_FB = 4'h2;
  localparam logic [3:0] DNC_SEC_HB2_FB = 4'h3;
  localparam logic [3:0] DNC_SEC_HB3_FB = 4'h4;
  localparam logic [3:0] DNC_MODE_MAP   = 4'h0;
  localparam logic [3:0] DNC_MODE_PINS  = 4'h1;
  localparam logic [3:0] DNC_MODE_EDGEA = 4'h8;
  localparam logic [3:0] DNC_MODE_EDGEB = 4'ha;
  localparam int DNC_ST_HB1 = 0;
  localparam int DNC_ST_HB2 = 1;
  localparam int DNC_ST_HB3 = 2;
  localparam int DNC_ST_HB4 = 3;
  localparam int DNC_ST_TB  = 4;
  localparam int DNC_ST_FB  = 5;

  typedef logic [5:0] dnc_stage_t;
  typedef enum logic {DNC_BUS_IDLE, DNC_BUS_DONE} dnc_bus_t;

endpackage

// >>> verilog/dnc_chan_if.sv
// Purpose: Carries oscillator channel selection between the two modules.
// Assumes: All signals belong to the single device clock domain.
// Notes:   The ctrl end owns the registers, the sel end owns the counter.
`timescale 1ns/10ps
interface dnc_chan_if;
  logic [3:0] mode;
  logic [3:0] map_chan;
  logic       pin_a;
  logic       pin_b;
  logic [3:0] chan;
  modport ctrl (output mode, output map_chan, output pin_a,
                output pin_b, input chan);
  modport sel  (input mode, input map_chan, input pin_a,
                input pin_b, output chan);
endinterface

// >>> verilog/dnc_chan_sel.sv
// Purpose: Oscillator channel selection from register, pins or counter.
// Assumes: Select pins are synchronous to clk_in.
// Notes:   The selected channel appears one clock after its cause, two clocks after a counted pin edge.
`timescale 1ns/10ps
module dnc_chan_sel
  import dnc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  dnc_chan_if.sel   chan_if
);

  logic       pin_a_q;
  logic       pin_b_q;
  logic [3:0] mode_prev_q;
  logic [3:0] cnt_q;
  logic [3:0] chan_q;
  logic [3:0] chan_d;
  logic       rise;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_a_q     <= 1'b0;
      pin_b_q     <= 1'b0;
      mode_prev_q <= DNC_NCO_RST[7:4];
    end else begin
      pin_a_q     <= chan_if.pin_a;
      pin_b_q     <= chan_if.pin_b;
      mode_prev_q <= chan_if.mode;
    end
  end

  assign rise = (chan_if.mode == DNC_MODE_EDGEA &&
                 chan_if.pin_a && !pin_a_q) ||
                (chan_if.mode == DNC_MODE_EDGEB &&
                 chan_if.pin_b && !pin_b_q);

  // A mode change restarts the sequence even if an edge lands with it.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= 4'h0;
    end else if (chan_if.mode != mode_prev_q) begin
      cnt_q <= 4'h0;
    end else if (rise) begin
      cnt_q <= (cnt_q >= chan_if.map_chan) ? 4'h0
                                           : cnt_q + 4'h1;
    end
  end

  always_comb begin
    chan_d = chan_if.map_chan;
    unique case (chan_if.mode)
      DNC_MODE_PINS:  chan_d = {2'b00, chan_if.pin_b,
                                chan_if.pin_a};
      DNC_MODE_EDGEA: chan_d = cnt_q;
      DNC_MODE_EDGEB: chan_d = cnt_q;
      default:        chan_d = chan_if.map_chan;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      chan_q <= 4'h0;
    end else begin
      chan_q <= chan_d;
    end
  end
  assign chan_if.chan = chan_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  edge_a_count_a: assert property (
    chan_if.mode == DNC_MODE_EDGEA && $stable(chan_if.mode) &&
    chan_if.pin_a && !pin_a_q && cnt_q < chan_if.map_chan
    |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("counter missed a first pin edge");
  edge_b_count_a: assert property (
    chan_if.mode == DNC_MODE_EDGEB && $stable(chan_if.mode) &&
    chan_if.pin_b && !pin_b_q && cnt_q < chan_if.map_chan
    |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("counter missed a second pin edge");
  counter_wrap_a: assert property (
    rise && $stable(chan_if.mode) && cnt_q >= chan_if.map_chan
    |=> cnt_q == 4'h0)
    else $error("counter did not wrap");
  mode_restart_a: assert property (
    $changed(chan_if.mode) |=> cnt_q == 4'h0 ##1 chan_q == 4'h0 ||
    chan_if.mode != $past(chan_if.mode) || chan_if.mode == DNC_MODE_MAP
    || chan_if.mode == DNC_MODE_PINS)
    else $error("counter did not restart on mode change");
  pin_channel_a: assert property (
    chan_if.mode == DNC_MODE_PINS
    |=> chan_q == {2'b00, $past(chan_if.pin_b), $past(chan_if.pin_a)})
    else $error("pin channel index wrong");
  map_channel_a: assert property (
    chan_if.mode == DNC_MODE_MAP |=> chan_q == $past(chan_if.map_chan))
    else $error("register channel not followed");
  wrap_seen_c: cover property (rise ##1 cnt_q == 4'h0);
endmodule

// >>> verilog/dnc_ddc_cfg.sv
// Purpose: Configuration of one downconverter channel: decimation cascade,
//          I and Q input routing and oscillator channel selection.
// Assumes: Avalon-MM slave with byte addresses; registers in lane 0.
// Notes:   Filters themselves live elsewhere; this block steers them.
//
// Behaviour
// - Primary code 011 uses first half-band only: by 1 real, 2 complex.
// - Primary code 100 uses first half-band plus third-band: by 3 or 6.
// - Primary code 101 uses two half-bands plus third-band: by 6 or 12.
// - Primary code 110 uses three half-bands plus third-band: 12 or 24.
// - Primary code 111 takes the cascade from the secondary nibble.
// - The secondary nibble is ignored unless the primary code is 111.
// - Secondary 0: third-band and four half-bands, by 48 or 24 real.
// - Secondary 2: fifth-band and first half-band, by 10 or 5 real.
// - Secondary 3: fifth-band and two half-bands, by 20 or 10 real.
// - Secondary 4: fifth-band and three half-bands, by 40 or 20 real.
// - Q select bit 2, reset 0, picks channel A or B for Q.
// - I select bit 0, reset 1, picks channel A or B for I.
// - Mode 0 takes the oscillator channel from the register field.
// - Mode 1 forms the channel as zero, zero, second pin, first pin.
// - Mode 8 counts rising edges of the first select pin.
// - Mode 10 counts rising edges of the second select pin.
// - The edge counter wraps to zero after reaching the register field.
// - Four-bit register field n selects oscillator channel n, reset 0.
// - Primary 000, 001, 010: two to four half-bands, by 2/4/8 or 4/8/16.
// - Complex-to-real on gives only the I stream; off, I and Q valid.
`timescale 1ns/10ps
module dnc_ddc_cfg
  import dnc_pkg::*;
#(
  parameter int SAMPLE_W = 14
) (
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic [11:0]         avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic      [31:0]         avs_readdata_out,
  output logic                     avs_waitrequest_out,
  input  wire logic                first_channel_select_pin_in,
  input  wire logic                second_channel_select_pin_in,
  input  wire logic [SAMPLE_W-1:0] adc_a_sample_in,
  input  wire logic [SAMPLE_W-1:0] adc_b_sample_in,
  output logic      [SAMPLE_W-1:0] i_sample_out,
  output logic      [SAMPLE_W-1:0] q_sample_out,
  output logic                     q_valid_out,
  output logic      [5:0]          stage_enable_out,
  output logic      [5:0]          decimation_out,
  output logic                     complex_to_real_out,
  output logic      [3:0]          oscillator_channel_out
);

  ////////////////////////////////////////////////////////////////////////
  // Register bus.

  dnc_bus_t      bus_q;
  logic [7:0]    ctrl_q;
  logic [7:0]    insel_q;
  logic [7:0]    nco_q;
  logic [31:0]   rdata_q;
  logic [7:0]    rd_mux;
  logic [9:0]    idx;
  logic          req;
  logic          wr_go;

  assign idx = avs_address_in[11:2];
  assign req = avs_read_in | avs_write_in;

  // One wait state gives the read mux a full cycle to settle.
  assign avs_waitrequest_out = req && (bus_q == DNC_BUS_IDLE);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus_q <= DNC_BUS_IDLE;
    end else begin
      unique case (bus_q)
        DNC_BUS_IDLE: bus_q <= req ? DNC_BUS_DONE : DNC_BUS_IDLE;
        DNC_BUS_DONE: bus_q <= DNC_BUS_IDLE;
      endcase
    end
  end

  assign wr_go = avs_write_in && (bus_q == DNC_BUS_DONE) &&
                 avs_byteenable_in[0];

  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      DNC_IDX_CTRL:  rd_mux = ctrl_q;
      DNC_IDX_INSEL: rd_mux = insel_q;
      DNC_IDX_NCO:   rd_mux = nco_q;
      default:       rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_in && bus_q == DNC_BUS_IDLE) begin
      rdata_q <= {24'h00_0000, rd_mux};
    end
  end
  assign avs_readdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= DNC_CTRL_RST;
    end else if (wr_go && idx == DNC_IDX_CTRL) begin
      ctrl_q <= avs_writedata_in[7:0] & DNC_CTRL_WMASK;
    end
  end

  // The reserved bits are masked so that they can never read back set.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      insel_q <= DNC_INSEL_RST;
    end else if (wr_go && idx == DNC_IDX_INSEL) begin
      insel_q <= avs_writedata_in[7:0] & DNC_INSEL_WMASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      nco_q <= DNC_NCO_RST;
    end else if (wr_go && idx == DNC_IDX_NCO) begin
      nco_q <= avs_writedata_in[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decimation cascade.

  logic [2:0]  dec_sel;
  logic [3:0]  sec_sel;
  logic        c2r;
  dnc_stage_t  stage_d;
  logic [5:0]  full_d;
  dnc_stage_t  stage_q;
  logic [5:0]  dec_q;
  logic        c2r_q;

  assign dec_sel = ctrl_q[DNC_DEC_LSB +: 3];
  assign sec_sel = insel_q[DNC_SEC_LSB +: 4];
  assign c2r     = ctrl_q[DNC_C2R_BIT];

  // Undocumented secondary codes leave every stage off and pass at 1, or report 0 with complex-to-real on.
  always_comb begin
    stage_d = '0;
    full_d  = 6'h01;
    unique case (dec_sel)
      DNC_DEC_HB12: begin
        stage_d = 6'h03;
        full_d  = 6'h04;
      end
      DNC_DEC_HB123: begin
        stage_d = 6'h07;
        full_d  = 6'h08;
      end
      DNC_DEC_HB1234: begin
        stage_d = 6'h0f;
        full_d  = 6'h10;
      end
      DNC_DEC_HB1: begin
        stage_d[DNC_ST_HB1] = 1'b1;
        full_d  = 6'h02;
      end
      DNC_DEC_HB1_TB: begin
        stage_d[DNC_ST_HB1] = 1'b1;
        stage_d[DNC_ST_TB]  = 1'b1;
        full_d  = 6'h06;
      end
      DNC_DEC_HB2_TB: begin
        stage_d = 6'h03;
        stage_d[DNC_ST_TB] = 1'b1;
        full_d  = 6'h0c;
      end
      DNC_DEC_HB3_TB: begin
        stage_d = 6'h07;
        stage_d[DNC_ST_TB] = 1'b1;
        full_d  = 6'h18;
      end
      DNC_DEC_SEC: begin
        unique case (sec_sel)
          DNC_SEC_HB4_TB: begin
            stage_d = 6'h0f;
            stage_d[DNC_ST_TB] = 1'b1;
            full_d  = 6'h30;
          end
          DNC_SEC_HB1_FB: begin
            stage_d[DNC_ST_HB1] = 1'b1;
            stage_d[DNC_ST_FB]  = 1'b1;
            full_d  = 6'h0a;
          end
          DNC_SEC_HB2_FB: begin
            stage_d = 6'h03;
            stage_d[DNC_ST_FB] = 1'b1;
            full_d  = 6'h14;
          end
          DNC_SEC_HB3_FB: begin
            stage_d = 6'h07;
            stage_d[DNC_ST_FB] = 1'b1;
            full_d  = 6'h28;
          end
          default: begin
            stage_d = '0;
            full_d  = 6'h01;
          end
        endcase
      end
    endcase
  end

  // Real output halves the rate, so the factor is shifted down by one.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stage_q <= DNC_STAGE_RST;
      dec_q   <= DNC_DEC_RST;
      c2r_q   <= 1'b0;
    end else begin
      stage_q <= stage_d;
      dec_q   <= c2r ? (full_d >> 1) : full_d;
      c2r_q   <= c2r;
    end
  end

  assign stage_enable_out    = stage_q;
  assign decimation_out      = dec_q;
  assign complex_to_real_out = c2r_q;

  ////////////////////////////////////////////////////////////////////////
  // Sample routing.

  logic [SAMPLE_W-1:0] i_q;
  logic [SAMPLE_W-1:0] q_q;
  logic                qv_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      i_q  <= '0;
      q_q  <= '0;
      qv_q <= 1'b0;
    end else begin
      i_q  <= insel_q[DNC_I_BIT] ? adc_b_sample_in
                                 : adc_a_sample_in;
      q_q  <= c2r ? '0 : (insel_q[DNC_Q_BIT] ? adc_b_sample_in
                                             : adc_a_sample_in);
      qv_q <= !c2r;
    end
  end

  assign i_sample_out = i_q;
  assign q_sample_out = q_q;
  assign q_valid_out  = qv_q;

  ////////////////////////////////////////////////////////////////////////
  // Oscillator channel selection.

  dnc_chan_if chan_if ();

  assign chan_if.mode     = nco_q[DNC_MODE_LSB +: 4];
  assign chan_if.map_chan = nco_q[DNC_CHAN_LSB +: 4];
  assign chan_if.pin_a    = first_channel_select_pin_in;
  assign chan_if.pin_b    = second_channel_select_pin_in;

  dnc_chan_sel u_chan_sel (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .chan_if  (chan_if.sel)
  );

  assign oscillator_channel_out = chan_if.chan;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  hb1_only_a: assert property (
    dec_sel == DNC_DEC_HB1 |=> stage_q == 6'h01 &&
    dec_q == ($past(c2r) ? 6'h01 : 6'h02))
    else $error("first half-band cascade wrong");
  hb1_third_a: assert property (
    dec_sel == DNC_DEC_HB1_TB |=> stage_q == 6'h11 &&
    dec_q == ($past(c2r) ? 6'h03 : 6'h06))
    else $error("half-band plus third-band cascade wrong");
  hb2_third_a: assert property (
    dec_sel == DNC_DEC_HB2_TB |=> stage_q == 6'h13 &&
    dec_q == ($past(c2r) ? 6'h06 : 6'h0c))
    else $error("two half-band plus third-band wrong");
  hb3_third_a: assert property (
    dec_sel == DNC_DEC_HB3_TB |=> stage_q == 6'h17 &&
    dec_q == ($past(c2r) ? 6'h0c : 6'h18))
    else $error("three half-band plus third-band wrong");
  sec_third_a: assert property (
    dec_sel == DNC_DEC_SEC && sec_sel == DNC_SEC_HB4_TB
    |=> stage_q == 6'h1f && dec_q == ($past(c2r) ? 6'h18 : 6'h30))
    else $error("secondary code 0 cascade wrong");
  sec_fifth_a: assert property (
    dec_sel == DNC_DEC_SEC && sec_sel == DNC_SEC_HB1_FB
    |=> stage_q == 6'h21 && dec_q == ($past(c2r) ? 6'h05 : 6'h0a))
    else $error("secondary code 2 cascade wrong");
  sec_fifth2_a: assert property (
    dec_sel == DNC_DEC_SEC && sec_sel == DNC_SEC_HB2_FB
    |=> stage_q == 6'h23 && dec_q == ($past(c2r) ? 6'h0a : 6'h14))
    else $error("secondary code 3 cascade wrong");
  sec_fifth3_a: assert property (
    dec_sel == DNC_DEC_SEC && sec_sel == DNC_SEC_HB3_FB
    |=> stage_q == 6'h27 && dec_q == ($past(c2r) ? 6'h14 : 6'h28))
    else $error("secondary code 4 cascade wrong");
  sec_ignored_a: assert property (
    dec_sel != DNC_DEC_SEC && $changed(sec_sel) && $stable(ctrl_q)
    |=> $stable(stage_q) && $stable(dec_q))
    else $error("secondary field acted outside code 111");
  reserved_zero_a: assert property (
    insel_q[3] == 1'b0 && insel_q[1] == 1'b0)
    else $error("reserved input select bits set");
  q_route_a: assert property (
    !c2r |=> q_q == ($past(insel_q[DNC_Q_BIT]) ? $past(adc_b_sample_in)
                                               : $past(adc_a_sample_in)))
    else $error("Q path routed from wrong channel");
  real_only_a: assert property (
    c2r |=> !q_valid_out && q_q == '0)
    else $error("Q path valid in real mode");

  real_mode_c:  cover property (c2r && dec_sel == DNC_DEC_SEC);
  fifth_band_c: cover property (stage_q[DNC_ST_FB]);
  write_done_c: cover property (wr_go ##2 avs_read_in);
endmodule

// >>> bench/dnc_ddc_cfg_tb_top.sv
// Purpose: Self-checking bench for the downconverter channel configuration.
// Assumes: Outputs settle within three clocks of the cause that sets them.
// Notes:   Checks wait a few clocks, except the osc check at 0f and the reset stage checks, which rely on the readbacks' cycles.
`timescale 1ns/10ps
module dnc_ddc_cfg_tb_top
  import dnc_pkg::*;
;
  localparam logic [11:0] A_CTRL  = {DNC_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_INSEL = {DNC_IDX_INSEL, 2'b00};
  localparam logic [11:0] A_NCO   = {DNC_IDX_NCO, 2'b00};
  localparam logic [13:0] SMP_A   = 14'h1a5a;
  localparam logic [13:0] SMP_B   = 14'h0c3c;

  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [11:0] address  = 12'h000;
  logic        read     = 1'b0;
  logic        write    = 1'b0;
  logic [31:0] wdata    = 32'h0;
  logic [3:0]  be       = 4'h1;
  logic        pin_a    = 1'b0;
  logic        pin_b    = 1'b0;
  logic [31:0] readdata;
  logic        waitreq;
  logic [13:0] i_s;
  logic [13:0] q_s;
  logic        q_valid;
  logic [5:0]  stages;
  logic [5:0]  dec;
  logic        c2r;
  logic [3:0]  osc;
  int          n_errors  = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  logic [5:0]  pst [7] = '{6'h03, 6'h07, 6'h0f, 6'h01, 6'h11, 6'h13, 6'h17};
  logic [5:0]  pdf [7] = '{6'h04, 6'h08, 6'h10, 6'h02, 6'h06, 6'h0c, 6'h18};
  logic [3:0]  scd [4] = '{4'h0, 4'h2, 4'h3, 4'h4};
  logic [5:0]  sst [4] = '{6'h1f, 6'h21, 6'h23, 6'h27};
  logic [5:0]  sdf [4] = '{6'h30, 6'h0a, 6'h14, 6'h28};

  always #10 clk_in = ~clk_in;

  dnc_ddc_cfg u_dnc_ddc_cfg (
    .clk_in                       (clk_in),
    .rst_n_in                     (rst_n_in),
    .avs_address_in               (address),
    .avs_read_in                  (read),
    .avs_write_in                 (write),
    .avs_writedata_in             (wdata),
    .avs_byteenable_in            (be),
    .avs_readdata_out             (readdata),
    .avs_waitrequest_out          (waitreq),
    .first_channel_select_pin_in  (pin_a),
    .second_channel_select_pin_in (pin_b),
    .adc_a_sample_in              (SMP_A),
    .adc_b_sample_in              (SMP_B),
    .i_sample_out                 (i_s),
    .q_sample_out                 (q_s),
    .q_valid_out                  (q_valid),
    .stage_enable_out             (stages),
    .decimation_out               (dec),
    .complex_to_real_out          (c2r),
    .oscillator_channel_out       (osc)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run for ever.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      results();
    end
  end

  task automatic cmp(input string nm, input logic [31:0] e, g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request is held until the edge at which waitrequest is low.
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, input logic [3:0] b,
                     output logic [31:0] rd);
    @(posedge clk_in);
    address <= a;
    wdata   <= {24'h0, d};
    be      <= b;
    read    <= ~wr;
    write   <= wr;
    do @(posedge clk_in); while (waitreq !== 1'b0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] b = 4'h1);
    logic [31:0] rd;
    bus(1'b1, a, d, b, rd);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] rd;
    bus(1'b0, a, 8'h00, 4'h1, rd);
    cmp("readdata", e, rd);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic pulse(input logic b);
    @(posedge clk_in);
    pin_a <= ~b;
    pin_b <= b;
    @(posedge clk_in);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    settle();
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(A_CTRL, 32'h00);
    rdc(A_INSEL, 32'h01);
    rdc(A_NCO, 32'h00);
    rdc(12'h004, 32'h00);
    cmp("stages", 32'(6'h03), 32'(stages));
    cmp("decimation", 32'(6'h04), 32'(dec));
  endtask

  task automatic t_decim();
    for (int r = 0; r < 2; r++) begin
      wr(A_INSEL, 8'h01);
      for (int p = 0; p < 7; p++) begin
        wr(A_CTRL, {4'h0, r[0], p[2:0]});
        settle();
        cmp("stages", 32'(pst[p]), 32'(stages));
        cmp("decimation", 32'(pdf[p] >> r),
            32'(dec));
        cmp("c2r", 32'(r[0]), 32'(c2r));
      end
      for (int s = 0; s < 4; s++) begin
        wr(A_INSEL, {scd[s], 4'h1});
        wr(A_CTRL, {4'h0, r[0], 3'h7});
        settle();
        cmp("stages", 32'(sst[s]), 32'(stages));
        cmp("decimation", 32'(sdf[s] >> r),
            32'(dec));
      end
      wr(A_CTRL, {4'h0, r[0], 3'h4});
      settle();
      cmp("stages", 32'(6'h11), 32'(stages));
      cmp("decimation", 32'(6'h06 >> r), 32'(dec));
    end
  endtask

  task automatic t_route();
    wr(A_CTRL, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(A_INSEL, {5'h0, k[1], 1'b0, k[0]});
      settle();
      cmp("i_sample", 32'(k[0] ? SMP_B : SMP_A), 32'(i_s));
      cmp("q_sample", 32'(k[1] ? SMP_B : SMP_A), 32'(q_s));
      cmp("q_valid", 32'h1, 32'(q_valid));
    end
    wr(A_CTRL, 8'h08);
    settle();
    cmp("q_sample", 32'h0, 32'(q_s));
    cmp("q_valid", 32'h0, 32'(q_valid));
    wr(A_INSEL, 8'hff);
    rdc(A_INSEL, 32'hf5);
    wr(A_INSEL, 8'h00, 4'h0);
    rdc(A_INSEL, 32'hf5);
    wr(A_INSEL, 8'h01);
    wr(A_CTRL, 8'h00);
  endtask

  task automatic t_chan();
    wr(A_NCO, 8'h04);
    settle();
    cmp("osc", 32'h4, 32'(osc));
    wr(A_NCO, 8'h0f);
    rdc(A_NCO, 32'h0f);
    cmp("osc", 32'hf, 32'(osc));
    wr(A_NCO, 8'h10);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      pin_a <= k[0];
      pin_b <= k[1];
      settle();
      cmp("osc", 32'(k), 32'(osc));
    end
    @(posedge clk_in);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    wr(A_NCO, 8'h82);
    settle();
    cmp("osc", 32'h0, 32'(osc));
    for (int k = 1; k < 5; k++) begin
      pulse(1'b0);
      cmp("osc", 32'(k % 3), 32'(osc));
    end
    wr(A_NCO, 8'ha2);
    settle();
    cmp("osc", 32'h0, 32'(osc));
    pulse(1'b1);
    cmp("osc", 32'h1, 32'(osc));
    pulse(1'b0);
    cmp("osc", 32'h1, 32'(osc));
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_decim();
    t_route();
    t_chan();
    results();
  end
endmodule
